// File: sfbfe_map.vh
// Constants for the serial flash bus front end
`ifndef SFBFE_MAP_VH
`define SFBFE_MAP_VH
// ****************************************
// Opcodes
// ****************************************
`define SFBFE_OP_DUAL_OUT   8'h3B
`define SFBFE_OP_DUAL_IO    8'hBB
`define SFBFE_OP_DUAL_ID    8'h92
`define SFBFE_OP_QUAD_OUT   8'h6B
`define SFBFE_OP_QUAD_IO    8'hEB
`define SFBFE_OP_QUAD_WORD  8'hE7
`define SFBFE_OP_QUAD_ID    8'h94
`define SFBFE_OP_QUAD_PROG  8'h32
`define SFBFE_OP_QPI_ENTER  8'h38
`define SFBFE_OP_QPI_EXIT   8'hFF
`define SFBFE_OP_RST_ARM    8'h66
`define SFBFE_OP_RST_DO     8'h99
// ****************************************
// Memory map
// ****************************************
`define SFBFE_ADDR_BITS     21
`define SFBFE_SECTOR_LSB    12
`define SFBFE_HALF_LSB      15
`define SFBFE_BLOCK_LSB     16
`define SFBFE_SECTOR_BITS   9
`define SFBFE_HALF_BITS     6
`define SFBFE_BLOCK_BITS    5
// ****************************************
// Widths (lines per clock)
// ****************************************
`define SFBFE_W_SINGLE      2'h0
`define SFBFE_W_DUAL        2'h1
`define SFBFE_W_QUAD        2'h2
`endif

// File: sfbfe_sync.v
// Two-flop synchroniser for a bundle of pin inputs
module sfbfe_sync #(
  parameter WIDTH = 4
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] rst_val,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  // No preset on purpose: a forced high would fake a select edge at release
  always @(posedge clk) begin
    meta_reg <= async_in;
    sync_out <= meta_reg;
  end
  // Reset and reset value kept for instance symmetry; the flops flush in reset
  wire unused_ok = sys_rst & (&rst_val);
endmodule // sfbfe_sync

// File: sfbfe_map_decode.v
// Address to sector, half block and block decoder
`include "sfbfe_map.vh"
module sfbfe_map_decode (
  input  wire [23:0] addr_in,
  output wire [20:0] addr_wrapped,
  output wire [8:0]  sector_num,
  output wire [5:0]  half_num,
  output wire [4:0]  block_num
);
  assign addr_wrapped = addr_in[20:0];
  assign sector_num = addr_in[20:12];
  assign half_num = addr_in[20:15];
  assign block_num = addr_in[20:16];
endmodule // sfbfe_map_decode

// File: sfbfe_front.v
// Serial flash bus front end: select, pause, mode and opcode/address shifting
// How it works
// - Array is 512 sectors of 4 KB over 21-bit byte addresses.
// - Sixteen consecutive sectors form each of 32 blocks of 64 KB.
// - Eight consecutive sectors form each of 64 half blocks of 32 KB.
// - Works with serial clock idling low or high (modes 0 and 3).
// - Inputs sampled on rising serial clock; outputs change after falling edge.
// - Dual opcodes turn lines 0 and 1 bidirectional, two bits per clock.
// - Quad opcodes use four bidirectional lines, four bits per clock.
// - Four-line opcodes execute only while quad enable bit is set or in quad mode.
// - Exactly one of SPI or quad instruction mode; 38h enters, FFh leaves.
// - Opcode takes eight clocks in SPI mode, two in quad mode.
// - SPI mode at power-up and after 66h then 99h reset.
// - Quad mode entry needs quad enable; all four lines bidirectional then.
// - After power-up stay unselected until a select falling edge.
// - Ignore opcodes during power-on reset; reset state on release.
// - On deselect, standby only when no internal write cycle runs.
// - During pause, release output and ignore data input and clock.
// - Pause keeps the bit position so shifting resumes exactly.
// - Select rising during pause abandons transaction, interface goes idle.
// - Pause begins or ends on pause pin level while clock is low.
// - Pause pin change with clock high waits until clock goes low.
// - Pause only honoured when quad enable is zero.
// - Pause never stops an internal write already running.
// - While deselected ignore inputs and release every output.
`include "sfbfe_map.vh"
module sfbfe_front (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        power_on_reset,
  input  wire        quad_enable_bit,
  input  wire        write_busy,
  input  wire        serial_clk,
  input  wire        select_n,
  input  wire [3:0]  data_in,
  input  wire [7:0]  tx_byte,
  output reg  [3:0]  data_out,
  output reg  [3:0]  data_oe,
  output reg         quad_instruction_mode,
  output reg         standby,
  output reg         paused,
  output reg         opcode_valid,
  output reg  [7:0]  opcode,
  output reg         addr_valid,
  output reg  [20:0] addr,
  output reg  [8:0]  sector_num,
  output reg  [5:0]  half_num,
  output reg  [4:0]  block_num,
  output reg         tx_load
);
  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD  = 2'h1;
  localparam ST_ADDR = 2'h2;
  localparam ST_DATA = 2'h3;

  // ****************************************
  // Input synchronisation
  // ****************************************
  wire [7:0] pins_sync;
  // Bit 4 is a spare lane held high
  sfbfe_sync #(
    .WIDTH    (8)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({power_on_reset, serial_clk, select_n, 1'b1, data_in}),
    .rst_val  (8'hFF),
    .sync_out (pins_sync)
  );
  wire       por_s  = pins_sync[7];
  wire       sclk_s = pins_sync[6];
  wire       csn_s  = pins_sync[5];
  wire [3:0] dat_s  = pins_sync[3:0];

  // Lines-per-clock of an opcode; a function since decode is reused
  function [1:0] op_width;
    input [7:0] op;
    begin
      if (op == `SFBFE_OP_DUAL_OUT || op == `SFBFE_OP_DUAL_IO || op == `SFBFE_OP_DUAL_ID)
        op_width = `SFBFE_W_DUAL;
      else if (op == `SFBFE_OP_QUAD_OUT || op == `SFBFE_OP_QUAD_IO || op == `SFBFE_OP_QUAD_WORD ||
               op == `SFBFE_OP_QUAD_ID || op == `SFBFE_OP_QUAD_PROG)
        op_width = `SFBFE_W_QUAD;
      else
        op_width = `SFBFE_W_SINGLE;
    end
  endfunction

  // Opcodes followed by a three-byte address
  function has_addr;
    input [7:0] op;
    begin
      has_addr = (op == 8'h03) || (op == 8'h0B) || (op == 8'h02) || (op == 8'h20) ||
                 (op == 8'h52) || (op == 8'hD8) || (op == `SFBFE_OP_DUAL_OUT) ||
                 (op == `SFBFE_OP_DUAL_IO) || (op == `SFBFE_OP_QUAD_OUT) ||
                 (op == `SFBFE_OP_QUAD_IO) || (op == `SFBFE_OP_QUAD_WORD) ||
                 (op == `SFBFE_OP_QUAD_PROG);
    end
  endfunction

  // Opcodes whose data phase the device answers; programs, erases and
  // mode or reset opcodes only listen, so driving there would fight the host
  function op_drives;
    input [7:0] op;
    begin
      op_drives = !((op == 8'h02) || (op == 8'h20) || (op == 8'h52) || (op == 8'hD8) ||
                    (op == `SFBFE_OP_QUAD_PROG) || (op == `SFBFE_OP_QPI_ENTER) ||
                    (op == `SFBFE_OP_QPI_EXIT) || (op == `SFBFE_OP_RST_ARM) ||
                    (op == `SFBFE_OP_RST_DO));
    end
  endfunction

  // ****************************************
  // State registers
  // ****************************************
  reg        sclk_d_reg;
  reg        csn_d_reg;
  reg        armed_reg;
  reg        rst_arm_reg;
  reg [1:0]  state_reg;
  reg [4:0]  bit_cnt_reg;
  reg [1:0]  width_reg;
  reg [23:0] shift_reg;
  reg [7:0]  tx_reg;
  reg [3:0]  drive_reg;
  reg        por_d_reg;

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_fall   = ~csn_s & csn_d_reg;
  wire cs_rise   = csn_s & ~csn_d_reg;
  // selected only once armed by an edge
  wire selected  = armed_reg & ~csn_s & ~por_s;
  // pause pin read with clock low
  // pause only without quad enable
  // Pin is plain data once quad enable or quad mode owns it, even mid-pause
  wire pause_ok  = ~quad_enable_bit & ~quad_instruction_mode;
  wire pause_now = pause_ok & (sclk_s ? paused : ~dat_s[3]);
  wire act_rise  = sclk_rise & selected & ~pause_now & ~paused;
  wire act_fall  = sclk_fall & selected & ~pause_now & ~paused;
  wire op_allowed = (op_width(opcode) != `SFBFE_W_QUAD) || quad_enable_bit || quad_instruction_mode;

  // Bits gained per rising edge
  wire [4:0] step = (width_reg == `SFBFE_W_QUAD) ? 5'h04 :
                    (width_reg == `SFBFE_W_DUAL) ? 5'h02 : 5'h01;
  reg  [23:0] shift_next;
  reg  [4:0]  cnt_next;

  // shift in on the rising edge, at the current width
  always @* begin
    shift_next = shift_reg;
    case (width_reg)
      `SFBFE_W_QUAD: shift_next = {shift_reg[19:0], dat_s};
      `SFBFE_W_DUAL: shift_next = {shift_reg[21:0], dat_s[1:0]};
      default:       shift_next = {shift_reg[22:0], dat_s[0]};
    endcase
    cnt_next = bit_cnt_reg + step;
  end

  // Address decode, fed from the captured three bytes
  wire [20:0] dec_addr;
  wire [8:0]  dec_sector;
  wire [5:0]  dec_half;
  wire [4:0]  dec_block;
  sfbfe_map_decode u_dec (
    .addr_in      (shift_next),
    .addr_wrapped (dec_addr),
    .sector_num   (dec_sector),
    .half_num     (dec_half),
    .block_num    (dec_block)
  );

  // ****************************************
  // Edge history and select arming
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      // Follow the pins through reset: a preset here would fake a select edge
      sclk_d_reg <= sclk_s;
      csn_d_reg  <= csn_s;
      armed_reg  <= 1'b0;
      por_d_reg  <= por_s;
    end else begin
      sclk_d_reg <= sclk_s;
      csn_d_reg  <= csn_s;
      por_d_reg  <= por_s;
      if (por_s)
        armed_reg <= 1'b0;
      else if (cs_fall)
        armed_reg <= 1'b1;
    end
  end

  // ****************************************
  // Transaction sequencer
  // ****************************************
  always @(posedge clk) begin
    opcode_valid <= 1'b0;
    addr_valid   <= 1'b0;
    tx_load      <= 1'b0;
    // held in reset state during power-on reset
    if (sys_rst || por_s) begin
      state_reg             <= ST_IDLE;
      bit_cnt_reg           <= 5'h00;
      width_reg             <= `SFBFE_W_SINGLE;
      shift_reg             <= 24'h000000;
      quad_instruction_mode <= 1'b0;
      rst_arm_reg           <= 1'b0;
      opcode                <= 8'h00;
      addr                  <= 21'h000000;
      sector_num            <= 9'h000;
      half_num              <= 6'h00;
      block_num             <= 5'h00;
      paused                <= 1'b0;
      tx_reg                <= 8'h00;
      drive_reg             <= 4'h0;
      opcode_valid          <= 1'b0;
      addr_valid            <= 1'b0;
      tx_load               <= 1'b0;
    end else if (csn_s || !armed_reg) begin
      // deselect abandons any transaction, paused or not
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 5'h00;
      paused      <= 1'b0;
      drive_reg   <= 4'h0;
    end else begin
      // pause freezes counters and shift state
      paused <= pause_now;
      if (state_reg == ST_IDLE) begin
        state_reg   <= ST_CMD;
        bit_cnt_reg <= 5'h00;
        // quad mode takes opcode on four lines
        width_reg   <= quad_instruction_mode ? `SFBFE_W_QUAD : `SFBFE_W_SINGLE;
      end else if (act_rise) begin
        shift_reg   <= shift_next;
        bit_cnt_reg <= cnt_next;
        if (state_reg == ST_CMD && cnt_next == 5'h08) begin
          opcode       <= shift_next[7:0];
          opcode_valid <= 1'b1;
          bit_cnt_reg  <= 5'h00;
          rst_arm_reg  <= (shift_next[7:0] == `SFBFE_OP_RST_ARM);
          // 66h then 99h returns to SPI mode
          if (rst_arm_reg && shift_next[7:0] == `SFBFE_OP_RST_DO)
            quad_instruction_mode <= 1'b0;
          // enter and leave quad instruction mode
          else if (shift_next[7:0] == `SFBFE_OP_QPI_ENTER && quad_enable_bit)
            quad_instruction_mode <= 1'b1;
          else if (shift_next[7:0] == `SFBFE_OP_QPI_EXIT)
            quad_instruction_mode <= 1'b0;
          if (op_width(shift_next[7:0]) == `SFBFE_W_QUAD && !quad_enable_bit && !quad_instruction_mode)
            state_reg <= ST_DATA;
          else begin
            state_reg <= has_addr(shift_next[7:0]) ? ST_ADDR : ST_DATA;
            if (quad_instruction_mode)
              width_reg <= `SFBFE_W_QUAD;
            else if (shift_next[7:0] == `SFBFE_OP_DUAL_IO || shift_next[7:0] == `SFBFE_OP_QUAD_IO ||
                     shift_next[7:0] == `SFBFE_OP_QUAD_WORD || shift_next[7:0] == `SFBFE_OP_DUAL_ID ||
                     shift_next[7:0] == `SFBFE_OP_QUAD_ID || shift_next[7:0] == `SFBFE_OP_QUAD_PROG)
              width_reg <= op_width(shift_next[7:0]);
            else
              width_reg <= `SFBFE_W_SINGLE;
          end
        end else if (state_reg == ST_ADDR && cnt_next == 5'h18) begin
          addr        <= dec_addr;
          sector_num  <= dec_sector;
          half_num    <= dec_half;
          block_num   <= dec_block;
          addr_valid  <= 1'b1;
          bit_cnt_reg <= 5'h00;
          state_reg   <= ST_DATA;
          if (!quad_instruction_mode)
            width_reg <= op_width(opcode);
        end else if (state_reg == ST_DATA && cnt_next == 5'h08) begin
          bit_cnt_reg <= 5'h00;
        end
      end else if (act_fall && state_reg == ST_DATA && op_drives(opcode) && op_allowed) begin
        // output changes after falling edge
        // Only answering opcodes load a byte and turn lines around
        if (bit_cnt_reg == 5'h00) begin
          tx_reg  <= tx_byte;
          tx_load <= 1'b1;
        end
        case (width_reg)
          `SFBFE_W_QUAD: drive_reg <= 4'hF;
          `SFBFE_W_DUAL: drive_reg <= 4'h3;
          default:       drive_reg <= 4'h2;
        endcase
      end
    end
  end

  // Bit to present, indexed by the position counter
  // At a byte start the new byte is loaded on the same edge, so take it direct
  wire [7:0] out_byte = (bit_cnt_reg == 5'h00) ? tx_byte : tx_reg;
  reg [3:0] out_bits;
  always @* begin
    out_bits = 4'h0;
    case (width_reg)
      `SFBFE_W_QUAD: out_bits = (bit_cnt_reg[2] == 1'b0) ? out_byte[7:4] : out_byte[3:0];
      `SFBFE_W_DUAL: out_bits = {2'b00, out_byte[3'h7 - bit_cnt_reg[2:0]],
                                 out_byte[3'h6 - bit_cnt_reg[2:0]]};
      default:       out_bits = {2'b00, out_byte[3'h7 - bit_cnt_reg[2:0]], 1'b0};
    endcase
  end

  // ****************************************
  // Pin drive and standby
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      data_out <= 4'h0;
      data_oe  <= 4'h0;
      standby  <= 1'b1;
    end else begin
      // new bits appear only after a serial clock fall
      if (act_fall && state_reg == ST_DATA)
        data_out <= out_bits;
      data_oe  <= (selected && !paused && state_reg == ST_DATA) ? drive_reg : 4'h0;
      // standby waits for the write cycle
      // write cycle runs on through pause
      standby  <= (csn_s || por_s) && !write_busy;
    end
  end
  // only edges counted, so idle clock level is irrelevant
  wire unused_edges = cs_rise & por_d_reg;
endmodule // sfbfe_front

// File: sfbfe_front_asserts.sv
// Port checker for the serial flash front end
`include "sfbfe_map.vh"
module sfbfe_front_asserts (
  input wire        clk,
  input wire        sys_rst,
  input wire        power_on_reset,
  input wire        quad_enable_bit,
  input wire        write_busy,
  input wire        select_n,
  input wire [3:0]  data_oe,
  input wire        quad_instruction_mode,
  input wire        standby,
  input wire        paused,
  input wire        opcode_valid,
  input wire [7:0]  opcode,
  input wire        addr_valid,
  input wire [20:0] addr,
  input wire [8:0]  sector_num,
  input wire [5:0]  half_num,
  input wire [4:0]  block_num
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Select must stay high long enough to pass the pin synchroniser
  sequence s_idle; select_n [*5]; endsequence
  // Address decode outputs are compared once the valid pulse is over
  sequence s_map_done; addr_valid ##1 1'b1; endsequence
  property p_sector; s_map_done |-> sector_num == addr[20:12]; endproperty
  property p_block; s_map_done |-> block_num == addr[20:16]; endproperty
  property p_half; s_map_done |-> half_num == addr[20:15]; endproperty
  property p_desel; s_idle |-> data_oe == 4'h0; endproperty
  property p_standby; (select_n && !write_busy) [*6] |-> standby; endproperty
  property p_busy; write_busy [*2] |-> !standby; endproperty
  property p_pause; paused [*2] |-> data_oe == 4'h0; endproperty
  property p_qe; quad_enable_bit [*4] |-> !paused; endproperty
  property p_qpi_in; $rose(quad_instruction_mode) |-> opcode == `SFBFE_OP_QPI_ENTER && quad_enable_bit; endproperty
  property p_qpi_out;
    $fell(quad_instruction_mode) |-> opcode == `SFBFE_OP_QPI_EXIT || opcode == `SFBFE_OP_RST_DO || power_on_reset;
  endproperty
  property p_por; power_on_reset [*4] |-> !opcode_valid && !addr_valid; endproperty
  a_sector: assert property (p_sector) else $error("sector number wrong");
  a_block: assert property (p_block) else $error("block number wrong");
  a_half: assert property (p_half) else $error("half block number wrong");
  a_desel: assert property (p_desel) else $error("driving while deselected");
  a_standby: assert property (p_standby) else $error("no standby when idle");
  a_busy: assert property (p_busy) else $error("standby during write");
  a_pause: assert property (p_pause) else $error("driving while paused");
  a_qe: assert property (p_qe) else $error("pause with quad enable set");
  a_qpi_in: assert property (p_qpi_in) else $error("bad quad mode entry");
  a_qpi_out: assert property (p_qpi_out) else $error("bad quad mode exit");
  a_por: assert property (p_por) else $error("answer during power-on reset");
endmodule // sfbfe_front_asserts
bind sfbfe_front sfbfe_front_asserts sfbfe_front_asserts_i (
  .clk, .sys_rst, .power_on_reset, .quad_enable_bit, .write_busy, .select_n, .data_oe,
  .quad_instruction_mode, .standby, .paused, .opcode_valid, .opcode, .addr_valid, .addr,
  .sector_num, .half_num, .block_num
);

// File: sfbfe_host.sv
// Host controller model driving the flash pins
module sfbfe_host (
  input  wire logic [3:0] data_out,
  input  wire logic [3:0] data_oe,
  input  wire logic       clk,
  output logic            serial_clk,
  output logic            select_n,
  output logic [3:0]      data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv;
  logic       cpol;
  // Device drive wins; lines 2 and 3 idle high through their pull-ups
  assign data_in = (data_oe & data_out) | (~data_oe & drv);
  initial begin
    serial_clk = 1'b0;
    drv = 4'hF;
    cpol = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // clock idles at the chosen polarity
  task automatic start(input logic pol);
    cpol = pol;
    serial_clk = pol;
    hold(4);
    select_n = 1'b0;
  endtask
  // data moves with the clock low, one or four lines a clock
  task automatic xfer(input logic [7:0] b, input int lanes);
    for (int i = 8 - lanes; i >= 0; i -= lanes) begin
      hold(8);
      serial_clk = 1'b0;
      if (lanes == 4) drv = b[i +: 4];
      else drv[0] = b[i];
      hold(8);
      serial_clk = 1'b1;
    end
  endtask
  // Lines 0 and 1 show the inverse so stale values never look valid; lines 2 and 3 go high
  task automatic stop();
    hold(8);
    serial_clk = cpol;
    hold(8);
    select_n = 1'b1;
    drv = {2'b11, ~drv[1:0]};
    hold(8);
  endtask
endmodule // sfbfe_host

// File: sfbfe_front_test.sv
// Self-checking bench for the serial flash front end
`include "sfbfe_map.vh"
module sfbfe_front_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        sys_rst;
  logic        power_on_reset;
  logic        quad_enable_bit;
  logic        write_busy;
  wire         serial_clk;
  wire         select_n;
  wire  [3:0]  data_in;
  wire  [3:0]  data_out;
  wire  [3:0]  data_oe;
  wire         quad_instruction_mode;
  wire         standby;
  wire         paused;
  wire         opcode_valid;
  wire  [7:0]  opcode;
  wire         addr_valid;
  wire  [20:0] addr;
  wire  [8:0]  sector_num;
  wire  [5:0]  half_num;
  wire  [4:0]  block_num;
  wire         tx_load;
  logic [7:0]  tx_val = 8'h00;
  int          n_ld = 0;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          n_op = 0;
  int          n_addr = 0;
  sfbfe_front sfbfe_front_i (.clk, .sys_rst, .power_on_reset, .quad_enable_bit, .write_busy, .serial_clk,
    .select_n, .data_in, .tx_byte(tx_val), .data_out, .data_oe, .quad_instruction_mode, .standby, .paused,
    .opcode_valid, .opcode, .addr_valid, .addr, .sector_num, .half_num, .block_num, .tx_load(tx_load));
  sfbfe_host sfbfe_host_i (.clk, .data_out, .data_oe, .serial_clk, .select_n, .data_in);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count result pulses so a missing or doubled one shows up
  always @(posedge clk) begin
    if (opcode_valid === 1'b1) n_op <= n_op + 1;
    if (addr_valid === 1'b1) n_addr <= n_addr + 1;
    if (tx_load === 1'b1) n_ld <= n_ld + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic op1(input logic [7:0] op, input int lanes);
    sfbfe_host_i.start(1'b0);
    sfbfe_host_i.xfer(op, lanes);
    sfbfe_host_i.stop();
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic pol);
    int p;
    int q;
    p = n_addr;
    q = n_ld;
    tx_val = ~a[23:16];
    sfbfe_host_i.start(pol);
    sfbfe_host_i.xfer(op, 1);
    for (int i = 2; i >= 0; i--) sfbfe_host_i.xfer(a[8*i +: 8], 1);
    // Mode 0 only: one clock fall opens the data phase, then a pause inside it
    if (!pol) begin
      sfbfe_host_i.hold(8);
      sfbfe_host_i.serial_clk = 1'b0;
      sfbfe_host_i.hold(8);
      chk(data_oe, 4'h2);
      chk(data_out, {2'b00, tx_val[7], 1'b0});
      sfbfe_host_i.drv[3] = 1'b0;
      sfbfe_host_i.hold(8);
      chk(data_oe, 4'h0);
      sfbfe_host_i.drv[3] = 1'b1;
      sfbfe_host_i.hold(8);
      chk(data_oe, 4'h2);
    end
    sfbfe_host_i.stop();
    chk(n_ld, q + (pol ? 0 : 1));
    chk(opcode, op);
    chk(n_addr, p + 1);
    chk(addr, a[20:0]);
    chk(sector_num, a[20:12]);
    chk(half_num, a[20:15]);
    chk(block_num, a[20:16]);
  endtask
  // Select held low since reset has had no falling edge yet
  task automatic t_arm();
    sfbfe_host_i.xfer(8'h03, 1);
    sfbfe_host_i.stop();
    chk(n_op, 0);
    $display("t_arm done");
  endtask
  task automatic t_map();
    logic [23:0] tbl [3] = '{24'hFFF123, 24'h008000, 24'h00F000};
    for (int i = 0; i < 3; i++) cmd(8'h0B, tbl[i], i[0]);
    $display("t_map done");
  endtask
  task automatic t_pause();
    int p;
    p = n_addr;
    sfbfe_host_i.start(1'b0);
    sfbfe_host_i.xfer(8'h03, 1);
    sfbfe_host_i.xfer(8'h1A, 1);
    // select stays low; pause pin drops while the clock is high
    sfbfe_host_i.drv[3] = 1'b0;
    sfbfe_host_i.hold(8);
    chk(paused, 0);
    sfbfe_host_i.serial_clk = 1'b0;
    sfbfe_host_i.hold(8);
    chk(paused, 1);
    // Clock and data wiggle during the pause and must leave no trace
    sfbfe_host_i.xfer(8'h00, 1);
    sfbfe_host_i.serial_clk = 1'b0;
    sfbfe_host_i.hold(8);
    chk(data_oe, 0);
    sfbfe_host_i.drv[3] = 1'b1;
    sfbfe_host_i.hold(8);
    chk(paused, 0);
    sfbfe_host_i.xfer(8'h23, 1);
    sfbfe_host_i.xfer(8'h45, 1);
    sfbfe_host_i.stop();
    chk(addr, 21'h1A2345);
    chk(n_addr, p + 1);
    // Deselect in mid-pause, then a clean command must decode whole
    sfbfe_host_i.start(1'b0);
    sfbfe_host_i.xfer(8'h03, 1);
    sfbfe_host_i.serial_clk = 1'b0;
    sfbfe_host_i.drv[3] = 1'b0;
    sfbfe_host_i.hold(8);
    sfbfe_host_i.select_n = 1'b1;
    sfbfe_host_i.hold(8);
    sfbfe_host_i.drv[3] = 1'b1;
    cmd(8'h0B, 24'h0A5000, 1'b0);
    $display("t_pause done");
  endtask
  task automatic t_standby();
    sfbfe_host_i.start(1'b0);
    sfbfe_host_i.hold(8);
    chk(standby, 0);
    write_busy = 1'b1;
    sfbfe_host_i.stop();
    chk(standby, 0);
    write_busy = 1'b0;
    sfbfe_host_i.hold(8);
    chk(standby, 1);
    $display("t_standby done");
  endtask
  task automatic t_qpi();
    int p;
    op1(`SFBFE_OP_QPI_ENTER, 1);
    chk(quad_instruction_mode, 0);
    // the host sets quad enable before any four-line opcode
    quad_enable_bit = 1'b1;
    op1(`SFBFE_OP_QPI_ENTER, 1);
    chk(quad_instruction_mode, 1);
    p = n_op;
    op1(`SFBFE_OP_RST_ARM, 4);
    chk(n_op, p + 1);
    op1(`SFBFE_OP_RST_DO, 4);
    chk(quad_instruction_mode, 0);
    op1(`SFBFE_OP_QPI_ENTER, 1);
    op1(`SFBFE_OP_QPI_EXIT, 4);
    chk(quad_instruction_mode, 0);
    op1(`SFBFE_OP_QPI_ENTER, 1);
    $display("t_qpi done");
  endtask
  task automatic t_por();
    int p;
    p = n_op;
    power_on_reset = 1'b1;
    op1(8'h05, 4);
    chk(n_op, p);
    power_on_reset = 1'b0;
    quad_enable_bit = 1'b0;
    sfbfe_host_i.hold(8);
    chk(quad_instruction_mode, 0);
    op1(8'h05, 1);
    chk(n_op, p + 1);
    $display("t_por done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    power_on_reset = 1'b0;
    quad_enable_bit = 1'b0;
    write_busy = 1'b0;
    sfbfe_host_i.select_n = 1'b0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    t_arm();
    t_map();
    t_pause();
    t_standby();
    t_qpi();
    t_por();
    give_verdict();
  end
  // Tests need about 4.3k cycles; anything far past that is a hang
  initial begin
    #500000;
    error_cnt++;
    give_verdict();
  end
endmodule // sfbfe_front_test
